/* sep_pkg.sv */
/*
 * Shared constants and types of the serial EEPROM slave: array geometry,
 * command field positions, protection control codes, programming times.
 * Assumes a 100 ns system clock; the two programming cycle counts below are derived from it.
 */
package sep_pkg;

	// --------------------------------------------------------------
	// Clock and programming times
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int T_WRITE_MS = 8;
	localparam int T_PROT_MS = 4;
	// Longest times, so the counts round down.
	localparam int WRITE_CYC = T_WRITE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int PROT_CYC = T_PROT_MS * 1000000 / CLK_PERIOD_NS;

	// --------------------------------------------------------------
	// Array geometry and field positions
	// --------------------------------------------------------------
	localparam int ADDR_W = 11;
	localparam int MEM_BYTES = 2048;
	localparam int PAGES = 128;
	localparam int PAGE_BYTES = 16;
	localparam int CMD_MARK_BIT = 7;
	localparam int CMD_RW_BIT = 0;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [4:0] VERIFY_BYTES = 5'h10;
	localparam logic [5:0] PROG_STEPS = 6'h20;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic PROT_RST = 1'b1;

	// --------------------------------------------------------------
	// Protection control codes
	// --------------------------------------------------------------
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_ERASE = 2'h3;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_CMD = 9'h002,
		ST_ADDR = 9'h004,
		ST_WDATA = 9'h008,
		ST_PCTL = 9'h010,
		ST_PVERIFY = 9'h020,
		ST_READ = 9'h040,
		ST_PREAD = 9'h080,
		ST_IGNORE = 9'h100
	} sep_state_t;

endpackage

/* sep_eeprom_slave.sv */
/*
 * Command and access logic of a 2048 x 8 two-wire serial EEPROM slave
 * with one protection bit per 16-byte page.
 * Assumes a free-running system clock, an asynchronous active-low reset,
 * and a bus master that owns the serial clock; the wired-AND data line is
 * resolved outside from sda_out and sda_oe.
 */
// Notes on behaviour
// - Acknowledge matching write-select command after START
// - Next byte loads low address bits
// - STOP starts erase then program cycle
// - Data programming ends within eight milliseconds
// - Page write takes one to sixteen bytes
// - Data entry increments only low four bits
// - Unaddressed page bytes stay unchanged
// - No acknowledge while programming
// - Address stays on last entered byte
// - Polling command acknowledged once cycle ends
// - Repeated START cancels write, read follows
// - Read sends eight bits, increments address
// - Plain read uses current address counter
// - Sequential read wraps whole memory to zero
// - Page writable only while protection bit one
// - Protected page write is suppressed
// - Protection bit addressed by page address
// - Control low bits select read, write, erase
// - Protection change needs sixteen matching bytes
// - Protection change leaves page data intact
// - Command byte fields and chip select compare
// - Protection cycle needs full verify, four milliseconds
// - Protection read returns bit, advances page
// - Write-protect input blocks all changes
`timescale 1ns/1ns
module sep_eeprom_slave #(
	parameter int WRITE_CYCLES = sep_pkg::WRITE_CYC,
	parameter int PROT_CYCLES = sep_pkg::PROT_CYC
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic chip_sel_in0,
	input wire logic chip_sel_in1,
	input wire logic chip_sel_in2,
	input wire logic write_protect,
	output logic busy
);

	localparam int TMR_MAX = (WRITE_CYCLES > PROT_CYCLES) ? WRITE_CYCLES : PROT_CYCLES;
	localparam int TMR_W = $clog2(TMR_MAX + 1);

	if (WRITE_CYCLES <= sep_pkg::PROG_STEPS || PROT_CYCLES <= sep_pkg::PROG_STEPS) begin : g_chk
		$error("Programming times must cover the 32 erase and program steps.");
	end

	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic [1:0] wp_sync_reg;
	logic [2:0] cs_meta_reg;
	logic [2:0] cs_sync_reg;
	logic scl_prev_reg;
	logic sda_prev_reg;
	logic [7:0] rx_shift_reg;
	logic [3:0] bit_cnt_reg;
	logic drive_reg;
	sep_pkg::sep_state_t state_reg;
	logic ack_pend_reg;
	logic tx_mode_reg;
	logic [7:0] tx_byte_reg;
	logic [10:0] addr_reg;
	logic [7:0] csw_reg;
	logic pend_prot_reg;
	logic [15:0] wmask_reg;
	logic [3:0] last_lo_reg;
	logic [4:0] ver_cnt_reg;
	logic [1:0] prot_op_reg;
	logic go_data_reg;
	logic go_prot_reg;
	logic busy_reg;
	logic prog_prot_reg;
	logic [TMR_W-1:0] timer_reg;
	logic [5:0] step_reg;
	logic [sep_pkg::PAGES-1:0] prot_bits_reg;
	logic [7:0] mem [sep_pkg::MEM_BYTES];
	logic [7:0] page_buf [sep_pkg::PAGE_BYTES];

	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic byte_done;
	logic ack_rise;
	logic cmd_ok;
	logic prog_done;
	logic mem_we;
	logic [6:0] page_next;
	logic [3:0] addr_lo;

	// ------------------------------------------------------------------
	// Pin synchronisers and bus conditions
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			wp_sync_reg <= 2'h0;
			cs_meta_reg <= 3'h0;
			cs_sync_reg <= 3'h0;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl};
			sda_sync_reg <= {sda_sync_reg[0], sda_in};
			wp_sync_reg <= {wp_sync_reg[0], write_protect};
			cs_meta_reg <= {chip_sel_in2, chip_sel_in1, chip_sel_in0};
			cs_sync_reg <= cs_meta_reg;
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
		end
	end

	assign scl_rise = scl_sync_reg[1] & ~scl_prev_reg;
	assign scl_fall = ~scl_sync_reg[1] & scl_prev_reg;
	assign start_cond = scl_sync_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_sync_reg[1];
	assign stop_cond = scl_sync_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_sync_reg[1];
	assign byte_done = scl_rise && bit_cnt_reg == sep_pkg::LAST_DATA_BIT && !tx_mode_reg;
	assign ack_rise = scl_rise && bit_cnt_reg == sep_pkg::ACK_SLOT;
	assign page_next = addr_reg[10:4] + 7'h01;
	assign addr_lo = addr_reg[3:0];

	// Fixed mark bit, chip select with the middle bit inverted.
	assign cmd_ok = rx_shift_reg[sep_pkg::CMD_MARK_BIT] &
		(rx_shift_reg[6] == cs_sync_reg[2]) & (rx_shift_reg[5] == ~cs_sync_reg[1]) &
		(rx_shift_reg[4] == cs_sync_reg[0]);

	// ------------------------------------------------------------------
	// Link domain: bits are taken on the rising serial clock.
	// ------------------------------------------------------------------
	// The word is read in the system domain only after the synchronised
	// eighth rising edge; it then holds until the next rising edge, which
	// is many system cycles away, so the word crosses while stable.
	always_ff @(posedge scl or negedge resetn) begin
		if (!resetn) begin
			rx_shift_reg <= 8'h00;
		end else begin
			rx_shift_reg <= {rx_shift_reg[6:0], sda_in};
		end
	end

	// ------------------------------------------------------------------
	// Bit counter and data line drive
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bit_cnt_reg <= 4'h0;
			drive_reg <= 1'b0;
		end else if (start_cond || stop_cond) begin
			bit_cnt_reg <= 4'h0;
			drive_reg <= 1'b0;
		end else begin
			if (scl_rise) begin
				bit_cnt_reg <= (bit_cnt_reg == sep_pkg::ACK_SLOT) ? 4'h0 : bit_cnt_reg + 4'h1;
			end
			// Changes only while the clock is low; MSB leaves first.
			if (scl_fall) begin
				if (bit_cnt_reg == sep_pkg::ACK_SLOT) begin
					drive_reg <= ack_pend_reg;
				end else begin
					drive_reg <= tx_mode_reg && !tx_byte_reg[3'h7 - bit_cnt_reg[2:0]];
				end
			end
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = drive_reg;
	assign busy = busy_reg;

	// ------------------------------------------------------------------
	// Protocol sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= sep_pkg::ST_IDLE;
			ack_pend_reg <= 1'b0;
			tx_mode_reg <= 1'b0;
			tx_byte_reg <= 8'h00;
			addr_reg <= 11'h000;
			csw_reg <= 8'h00;
			pend_prot_reg <= 1'b0;
			wmask_reg <= 16'h0000;
			last_lo_reg <= 4'h0;
			ver_cnt_reg <= 5'h00;
			prot_op_reg <= sep_pkg::OP_READ;
			go_data_reg <= 1'b0;
			go_prot_reg <= 1'b0;
		end else begin
			go_data_reg <= 1'b0;
			go_prot_reg <= 1'b0;
			if (prog_done) begin
				addr_reg[3:0] <= prog_prot_reg ? 4'hf : last_lo_reg;
			end
			if (start_cond) begin
				// A repeated START abandons any write in progress.
				state_reg <= sep_pkg::ST_CMD;
				ack_pend_reg <= 1'b0;
				tx_mode_reg <= 1'b0;
			end else if (stop_cond) begin
				if (state_reg == sep_pkg::ST_WDATA && wmask_reg != 16'h0000 &&
						!wp_sync_reg[1] && prot_bits_reg[addr_reg[10:4]]) begin
					go_data_reg <= 1'b1;
				end
				if (state_reg == sep_pkg::ST_PVERIFY && ver_cnt_reg == sep_pkg::VERIFY_BYTES &&
						!wp_sync_reg[1]) begin
					go_prot_reg <= 1'b1;
				end
				state_reg <= sep_pkg::ST_IDLE;
				ack_pend_reg <= 1'b0;
				tx_mode_reg <= 1'b0;
				pend_prot_reg <= 1'b0;
			end else if (ack_rise && !ack_pend_reg && tx_mode_reg) begin
				if (!sda_sync_reg[1] && state_reg == sep_pkg::ST_READ) begin
					tx_byte_reg <= mem[addr_reg];
					addr_reg <= addr_reg + 11'h001;
				end else if (!sda_sync_reg[1]) begin
					addr_reg[10:4] <= page_next;
					tx_byte_reg <= {prot_bits_reg[page_next], 7'h00};
				end else begin
					// Released line ends the read until the next START.
					tx_mode_reg <= 1'b0;
					state_reg <= sep_pkg::ST_IGNORE;
				end
			end else if (ack_rise) begin
				ack_pend_reg <= 1'b0;
			end else if (byte_done) begin
				ack_pend_reg <= 1'b0;
				unique case (state_reg)
					sep_pkg::ST_CMD: begin
						if (!cmd_ok || busy_reg) begin
							state_reg <= sep_pkg::ST_IGNORE;
						end else if (rx_shift_reg[sep_pkg::CMD_RW_BIT]) begin
							ack_pend_reg <= 1'b1;
							state_reg <= sep_pkg::ST_READ;
							tx_mode_reg <= 1'b1;
							tx_byte_reg <= mem[addr_reg];
							addr_reg <= addr_reg + 11'h001;
							pend_prot_reg <= 1'b0;
						end else if (pend_prot_reg && rx_shift_reg == csw_reg) begin
							ack_pend_reg <= 1'b1;
							state_reg <= sep_pkg::ST_PCTL;
						end else begin
							ack_pend_reg <= 1'b1;
							state_reg <= sep_pkg::ST_ADDR;
							csw_reg <= rx_shift_reg;
							pend_prot_reg <= 1'b0;
						end
					end
					sep_pkg::ST_ADDR: begin
						ack_pend_reg <= 1'b1;
						addr_reg <= {csw_reg[3:1], rx_shift_reg};
						state_reg <= sep_pkg::ST_WDATA;
						wmask_reg <= 16'h0000;
						pend_prot_reg <= 1'b1;
					end
					sep_pkg::ST_WDATA: begin
						ack_pend_reg <= 1'b1;
						wmask_reg[addr_reg[3:0]] <= 1'b1;
						last_lo_reg <= addr_reg[3:0];
						addr_reg[3:0] <= addr_reg[3:0] + 4'h1;
						pend_prot_reg <= 1'b0;
					end
					sep_pkg::ST_PCTL: begin
						if (rx_shift_reg[1:0] == sep_pkg::OP_READ) begin
							ack_pend_reg <= 1'b1;
							state_reg <= sep_pkg::ST_PREAD;
							tx_mode_reg <= 1'b1;
							tx_byte_reg <= {prot_bits_reg[addr_reg[10:4]], 7'h00};
						end else if (rx_shift_reg[1:0] == sep_pkg::OP_WRITE ||
								rx_shift_reg[1:0] == sep_pkg::OP_ERASE) begin
							ack_pend_reg <= 1'b1;
							state_reg <= sep_pkg::ST_PVERIFY;
							prot_op_reg <= rx_shift_reg[1:0];
							ver_cnt_reg <= 5'h00;
						end else begin
							state_reg <= sep_pkg::ST_IGNORE;
						end
					end
					sep_pkg::ST_PVERIFY: begin
						if (ver_cnt_reg != sep_pkg::VERIFY_BYTES &&
								rx_shift_reg == mem[{addr_reg[10:4], ver_cnt_reg[3:0]}]) begin
							ack_pend_reg <= 1'b1;
							ver_cnt_reg <= ver_cnt_reg + 5'h01;
						end else begin
							state_reg <= sep_pkg::ST_IGNORE;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Page buffer holds entered data until the cycle programs it.
	always_ff @(posedge sys_clk) begin
		if (byte_done && !start_cond && !stop_cond && state_reg == sep_pkg::ST_WDATA) begin
			page_buf[addr_reg[3:0]] <= rx_shift_reg;
		end
	end

	// ------------------------------------------------------------------
	// Internally timed programming cycle
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			busy_reg <= 1'b0;
			prog_prot_reg <= 1'b0;
			timer_reg <= '0;
			step_reg <= 6'h00;
		end else if (go_data_reg || go_prot_reg) begin
			busy_reg <= 1'b1;
			prog_prot_reg <= go_prot_reg;
			timer_reg <= go_prot_reg ? TMR_W'(PROT_CYCLES - 1) : TMR_W'(WRITE_CYCLES - 1);
			step_reg <= 6'h00;
		end else if (busy_reg) begin
			if (timer_reg == '0) begin
				busy_reg <= 1'b0;
			end else begin
				timer_reg <= timer_reg - TMR_W'(1);
			end
			if (step_reg != sep_pkg::PROG_STEPS) begin
				step_reg <= step_reg + 6'h01;
			end
		end
	end

	assign prog_done = busy_reg && timer_reg == '0;

	// First sixteen steps erase, next sixteen program; only entered bytes.
	assign mem_we = busy_reg && !prog_prot_reg && step_reg != sep_pkg::PROG_STEPS &&
		wmask_reg[step_reg[3:0]];

	// The array has no reset; its contents are undefined until written.
	always_ff @(posedge sys_clk) begin
		if (mem_we) begin
			mem[{addr_reg[10:4], step_reg[3:0]}] <=
				step_reg[4] ? page_buf[step_reg[3:0]] : sep_pkg::ERASED_BYTE;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prot_bits_reg <= {sep_pkg::PAGES{sep_pkg::PROT_RST}};
		end else if (prog_done && prog_prot_reg) begin
			prot_bits_reg[addr_reg[10:4]] <= (prot_op_reg == sep_pkg::OP_ERASE);
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	a_ack_drive: assert property (scl_fall && bit_cnt_reg == sep_pkg::ACK_SLOT && ack_pend_reg
		|=> sda_oe) else $error("Acknowledge slot not driven.");
	a_addr_load: assert property (byte_done && state_reg == sep_pkg::ST_ADDR
		|=> addr_reg[7:0] == $past(rx_shift_reg) && state_reg == sep_pkg::ST_WDATA)
		else $error("Low address byte not loaded.");
	a_page_wrap: assert property (byte_done && state_reg == sep_pkg::ST_WDATA
		|=> $stable(addr_reg[10:4]) && addr_lo == $past(addr_lo) + 4'h1)
		else $error("Page entry left its page.");
	a_busy_nack: assert property (byte_done && state_reg == sep_pkg::ST_CMD && busy_reg
		|=> !ack_pend_reg && state_reg == sep_pkg::ST_IGNORE)
		else $error("Command acknowledged while programming.");
	a_csel_nack: assert property (byte_done && state_reg == sep_pkg::ST_CMD && !cmd_ok
		|=> state_reg == sep_pkg::ST_IGNORE ##1 !ack_pend_reg)
		else $error("Foreign command not ignored.");
	a_read_incr: assert property (byte_done && state_reg == sep_pkg::ST_CMD && cmd_ok &&
		!busy_reg && rx_shift_reg[0] |=> addr_reg == $past(addr_reg) + 11'h001 && tx_mode_reg)
		else $error("Read did not advance the address.");
	a_write_time: assert property (go_data_reg
		|=> busy_reg && timer_reg == TMR_W'(WRITE_CYCLES - 1))
		else $error("Write cycle length wrong.");
	a_busy_end: assert property (busy_reg && timer_reg == '0 |=> !busy_reg)
		else $error("Programming overran its time.");
	a_prot_guard: assert property (stop_cond && state_reg == sep_pkg::ST_WDATA &&
		(wp_sync_reg[1] || !prot_bits_reg[addr_reg[10:4]]) |=> !go_data_reg ##1 !busy_reg)
		else $error("Protected page was programmed.");
	a_prot_verify: assert property (go_prot_reg |-> $past(ver_cnt_reg) == sep_pkg::VERIFY_BYTES)
		else $error("Protection cycle without full verify.");
	a_prot_keep: assert property (busy_reg && prog_prot_reg |-> !mem_we)
		else $error("Page data changed by protection cycle.");

endmodule

/* sep_i2c_master.sv */
/*
 * Two-wire bus master model: START, STOP and nine-clock byte transfers.
 * Assumes the bench resolves the open-drain data line with a pull-up.
 */
`timescale 1ns/1ns
module sep_i2c_master (
	input wire logic sys_clk,
	input wire logic sda,
	output logic scl,
	output logic sda_rel
);
	// Each clock phase spans HALF system clocks, above the slave's minimum of eight.
	localparam int HALF = 10;
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic start();
		tick(4);
		sda_rel = 1'b1;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		sda_rel = 1'b0;
		tick(HALF);
		scl = 1'b0;
	endtask
	task automatic stop();
		tick(4);
		sda_rel = 1'b0;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		sda_rel = 1'b1;
		tick(HALF);
	endtask
	task automatic bit_io(input logic b, output logic s);
		tick(4);
		sda_rel = b;
		tick(HALF - 4);
		scl = 1'b1;
		tick(HALF / 2);
		s = sda;
		tick(HALF / 2);
		scl = 1'b0;
	endtask
	// A one in the ninth slot leaves the line released, so the slave stops sending.
	task automatic xfer(input logic [7:0] d, input logic nack, output logic [7:0] q,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
			q[i] = s;
		end
		bit_io(nack, s);
		ack = ~s;
	endtask
endmodule

/* test_serial_eeprom_access_page_protect.sv */
/*
 * Self-checking bench for the serial EEPROM slave, driven by a bus master model.
 * Assumes the programming times are shortened through the slave's parameters.
 */
`timescale 1ns/1ns
module test_serial_eeprom_access_page_protect;
	// Short enough for a quick run, long enough that the first poll is refused.
	localparam int PROG_CYC = 600;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic scl;
	logic sda;
	logic sda_rel;
	logic sda_out;
	logic sda_oe;
	logic chip_sel_in0 = 1'b1;
	logic chip_sel_in1 = 1'b0;
	logic chip_sel_in2 = 1'b1;
	logic write_protect = 1'b0;
	logic busy;
	int failures = 0;
	int total_checks = 0;
	logic [7:0] shadow [2048];
	logic prot [128];
	always #50 sys_clk = ~sys_clk;
	assign sda = (sda_oe ? sda_out : 1'b1) & sda_rel;
	sep_i2c_master m (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
	sep_eeprom_slave #(.WRITE_CYCLES(PROG_CYC), .PROT_CYCLES(PROG_CYC)) dut (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.scl(scl),
		.sda_in(sda),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.chip_sel_in0(chip_sel_in0),
		.chip_sel_in1(chip_sel_in1),
		.chip_sel_in2(chip_sel_in2),
		.write_protect(write_protect),
		.busy(busy)
	);
	task automatic finish_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [7:0] write_select_cmd(input logic [10:0] a);
		return {1'b1, chip_sel_in2, ~chip_sel_in1, chip_sel_in0, a[10:8], 1'b0};
	endfunction
	// -------------------------------------------------------------
	// Transfer and scenario tasks
	// -------------------------------------------------------------
	task automatic put(input logic [7:0] d, input logic exp, input string nm);
		logic [7:0] q;
		logic a;
		m.xfer(d, 1'b1, q, a);
		check(nm, {7'h0, a}, {7'h0, exp});
	endtask
	task automatic setaddr(input logic [10:0] a);
		m.start();
		put(write_select_cmd(a), 1'b1, "csw_ack");
		put(a[7:0], 1'b1, "addr_ack");
	endtask
	// Polls with the same upper address bits, so the counter is not disturbed.
	task automatic poll(input logic [10:0] a, input logic prog);
		logic [7:0] q;
		logic ack;
		int n;
		n = 0;
		ack = 1'b0;
		while (ack !== 1'b1 && n < 8) begin
			m.start();
			m.xfer(write_select_cmd(a), 1'b1, q, ack);
			n++;
			if (prog && n == 1) check("poll_refused", {7'h0, ack}, 8'h0);
		end
		m.stop();
		check("poll_done", {7'h0, ack}, 8'h1);
		if (prog) check("poll_tries", {7'h0, n < 5}, 8'h1);
	endtask
	task automatic wr(input logic [10:0] a, input int n, input logic [7:0] base, input logic prog);
		logic [7:0] q;
		logic ack;
		setaddr(a);
		for (int i = 0; i < n; i++) begin
			m.xfer(base + 8'(i), 1'b1, q, ack);
			check("data_ack", {7'h0, ack}, 8'h1);
			if (prog) shadow[{a[10:4], a[3:0] + 4'(i)}] = base + 8'(i);
		end
		m.stop();
		check("busy", {7'h0, busy}, {7'h0, prog});
		poll(a, prog);
	endtask
	task automatic rd(input logic [10:0] a, input int n, input logic seek);
		logic [7:0] q;
		logic ack;
		if (seek) setaddr(a);
		m.start();
		put(write_select_cmd(a) | 8'h01, 1'b1, "csr_ack");
		for (int i = 0; i < n; i++) begin
			m.xfer(8'hff, i == n - 1, q, ack);
			check("rdata", q, shadow[a + 11'(i)]);
		end
		m.stop();
	endtask
	task automatic pctl(input logic [10:0] pg, input logic [1:0] op);
		setaddr(pg);
		m.start();
		put(write_select_cmd(pg), 1'b1, "csw2_ack");
		put({6'h2a, op}, op != 2'h2, "ctl_ack");
	endtask
	// The unused control code must be refused and must start no cycle.
	task automatic bad_ctl();
		pctl(11'h140, 2'h2);
		m.stop();
		check("bad_ctl_busy", {7'h0, busy}, 8'h0);
	endtask
	task automatic pread(input logic [10:0] pg);
		logic [7:0] q;
		logic ack;
		pctl(pg, sep_pkg::OP_READ);
		m.xfer(8'hff, 1'b0, q, ack);
		check("pbit", {7'h0, q[7]}, {7'h0, prot[pg[10:4]]});
		m.xfer(8'hff, 1'b1, q, ack);
		check("pbit_next", {7'h0, q[7]}, {7'h0, prot[pg[10:4] + 7'h1]});
		m.stop();
	endtask
	// A bad index below 16 corrupts that verify byte; the change must then be dropped.
	task automatic pchg(input logic [10:0] pg, input logic [1:0] op, input int bad);
		logic [7:0] q;
		logic ack;
		pctl(pg, op);
		for (int i = 0; i < 16; i++) begin
			m.xfer(shadow[pg + 11'(i)] ^ {7'h0, i == bad}, 1'b1, q, ack);
			check("verify_ack", {7'h0, ack}, {7'h0, i < bad});
		end
		m.stop();
		if (bad == 16) prot[pg[10:4]] = (op == sep_pkg::OP_ERASE);
		poll(pg, bad == 16);
	endtask
	task automatic wrong_select();
		logic [7:0] masks [4] = '{8'h80, 8'h40, 8'h20, 8'h10};
		foreach (masks[i]) begin
			m.start();
			put(write_select_cmd(11'h0) ^ masks[i], 1'b0, "cs_refused");
			put(8'h00, 1'b0, "ignored");
			m.stop();
		end
	endtask
	initial begin
		for (int i = 0; i < 128; i++) prot[i] = 1'b1;
		repeat (5) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (6) @(negedge sys_clk);
		wr(11'h123, 1, 8'ha5, 1'b1);
		rd(11'h123, 1, 1'b1);
		wr(11'h140, 16, 8'h30, 1'b1);
		wr(11'h14e, 3, 8'h80, 1'b1);
		rd(11'h140, 1, 1'b0);
		rd(11'h140, 16, 1'b1);
		wr(11'h7ff, 1, 8'h5a, 1'b1);
		wr(11'h000, 1, 8'hc3, 1'b1);
		rd(11'h7ff, 2, 1'b1);
		wrong_select();
		pread(11'h140);
		pchg(11'h140, sep_pkg::OP_WRITE, 16);
		pread(11'h140);
		wr(11'h141, 1, 8'h99, 1'b0);
		rd(11'h140, 16, 1'b1);
		pchg(11'h140, sep_pkg::OP_ERASE, 5);
		bad_ctl();
		pread(11'h140);
		pchg(11'h140, sep_pkg::OP_ERASE, 16);
		pread(11'h130);
		pread(11'h7f0);
		wr(11'h141, 1, 8'h99, 1'b1);
		rd(11'h140, 16, 1'b1);
		write_protect = 1'b1;
		wr(11'h000, 1, 8'h11, 1'b0);
		rd(11'h000, 1, 1'b1);
		finish_test();
	end
	initial begin
		repeat (95000) @(posedge sys_clk);
		failures++;
		finish_test();
	end
endmodule
